// file: amp_power_gain_config_params.svh
`ifndef AMP_POWER_GAIN_CONFIG_PARAMS_SVH
`define AMP_POWER_GAIN_CONFIG_PARAMS_SVH

`define OFS_BLOCK_POWER_ENABLES   8'h05
`define OFS_GAIN_AND_EDGE_RATE    8'h06
`define OFS_SENSE_MUTE_CONTROL    8'h07
`define OFS_SENSE_RANGE_CONTROL   8'h08
`define OFS_BOOST_MODE_CONTROL    8'h09
`define REG_RESET_VALUE           8'h00
`define BIT_SPEAKER_STAGE_POWER   7
`define BIT_BOOST_POWER           5
`define BIT_CURRENT_ADC_POWER     1
`define BIT_VOLTAGE_ADC_POWER     0
`define POS_DAC_GAIN_HI           6
`define POS_DAC_GAIN_LO           3
`define POS_EDGE_RATE_HI          2
`define POS_EDGE_RATE_LO          0
`define BIT_CURRENT_SILENCE       1
`define BIT_VOLTAGE_SILENCE       0
`define POS_SENSE_RANGE_HI        2
`define POS_SENSE_RANGE_LO        1
`define BIT_BOOST_LEVEL_SCHEME    0

`endif

// file: amp_cfg_pkg.sv
package amp_cfg_pkg;
    typedef enum logic [1:0] {
        RANGE_8_OHM,
        RANGE_6_OHM,
        RANGE_4_OHM,
        RANGE_UNDEFINED
    } sense_range_e;
    typedef enum logic {
        BOOST_MULTI_LEVEL,
        BOOST_SINGLE_LEVEL
    } boost_scheme_e;
    typedef logic [7:0] reg_byte_t;
endpackage

// file: cfg_byte_reg.sv
`timescale 1ns/1ps
`include "amp_power_gain_config_params.svh"
module cfg_byte_reg
    import amp_cfg_pkg::*;
(
    input  wire logic      mclk,
    input  wire logic      rst_n,
    input  wire logic      wr_en,
    input  wire reg_byte_t wr_data,
    output reg_byte_t      q
);
    // all bits, reserved included, store what was written
    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            q <= `REG_RESET_VALUE;
        end else if (wr_en) begin
            q <= wr_data;
        end
    end
endmodule

// file: amp_power_gain_config.sv
`timescale 1ns/1ps
`include "amp_power_gain_config_params.svh"
// Behaviour
// - register 0x05 bits 7,5,1,0 power speaker, boost, current and voltage ADC
// - gain register bits 6..3 give DAC gain of n dB, 0 to 15
// - gain register bits 2..0 select edge rate 50,40,29,25,14,13,12,11 ns
// - register 0x07 bit 1 mutes current sense, bit 0 voltage sense
// - register 0x08 bits 2..1 pick sense range 8, 6 or 4 ohm load
// - boost register bit 0 low runs multi-level tracking boost
// - boost register bit 0 high runs single-level switched boost
module amp_power_gain_config
    import amp_cfg_pkg::*;
(
    input  wire logic    mclk,
    input  wire logic    rst_n,
    input  wire logic    reg_wr,
    input  wire logic    reg_rd,
    input  wire logic [7:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    output logic [7:0]   reg_rdata,
    output logic         reg_hit,
    output logic         speaker_stage_power,
    output logic         boost_power,
    output logic         current_adc_power,
    output logic         voltage_adc_power,
    output logic [3:0]   dac_gain_db,
    output logic [2:0]   edge_rate_code,
    output logic         current_channel_silence,
    output logic         voltage_channel_silence,
    output sense_range_e sense_range_code,
    output boost_scheme_e boost_level_scheme
);
    localparam int NREG = 5;

    function automatic logic [2:0] addr_index(input logic [7:0] a);
        addr_index = 3'(a - `OFS_BLOCK_POWER_ENABLES);
    endfunction
    function automatic logic addr_valid(input logic [7:0] a);
        addr_valid = (a >= `OFS_BLOCK_POWER_ENABLES) &&
                     (a <= `OFS_BOOST_MODE_CONTROL);
    endfunction

    reg_byte_t        regs [NREG];
    logic [NREG-1:0]  wr_sel;
    wire  logic       addr_ok = addr_valid(reg_addr);
    wire  logic [2:0] idx     = addr_index(reg_addr);

    genvar g;
    generate
        for (g = 0; g < NREG; g++) begin : g_regs
            assign wr_sel[g] = reg_wr && addr_ok && (idx == 3'(g));
            cfg_byte_reg u_reg (
                .mclk    (mclk),
                .rst_n   (rst_n),
                .wr_en   (wr_sel[g]),
                .wr_data (reg_wdata),
                .q       (regs[g])
            );
        end
    endgenerate

    wire reg_byte_t pwr_r   = regs[0];
    wire reg_byte_t gain_r  = regs[1];
    wire reg_byte_t mute_r  = regs[2];
    wire reg_byte_t range_r = regs[3];
    wire reg_byte_t boost_r = regs[4];
    // unmapped reads return zero
    wire reg_byte_t rdata_nxt = (reg_rd && addr_ok) ? regs[idx] : 8'h00;
    // a write to 0x05..0x09 shows on the field outputs on the same edge that stores it
    wire reg_byte_t pwr_nxt   = wr_sel[0] ? reg_wdata : pwr_r;
    wire reg_byte_t gain_nxt  = wr_sel[1] ? reg_wdata : gain_r;
    wire reg_byte_t mute_nxt  = wr_sel[2] ? reg_wdata : mute_r;
    wire reg_byte_t range_nxt = wr_sel[3] ? reg_wdata : range_r;
    wire reg_byte_t boost_nxt = wr_sel[4] ? reg_wdata : boost_r;

    always_ff @(posedge mclk) begin
        if (!rst_n) begin
            reg_rdata               <= 8'h00;
            reg_hit                 <= 1'b0;
            speaker_stage_power     <= 1'b0;
            boost_power             <= 1'b0;
            current_adc_power       <= 1'b0;
            voltage_adc_power       <= 1'b0;
            dac_gain_db             <= 4'h0;
            edge_rate_code          <= 3'h0;
            current_channel_silence <= 1'b0;
            voltage_channel_silence <= 1'b0;
            sense_range_code        <= RANGE_8_OHM;
            boost_level_scheme      <= BOOST_MULTI_LEVEL;
        end else begin
            reg_rdata <= rdata_nxt;
            reg_hit   <= (reg_rd || reg_wr) && addr_ok;
            speaker_stage_power <= pwr_nxt[`BIT_SPEAKER_STAGE_POWER];
            boost_power         <= pwr_nxt[`BIT_BOOST_POWER];
            current_adc_power   <= pwr_nxt[`BIT_CURRENT_ADC_POWER];
            voltage_adc_power   <= pwr_nxt[`BIT_VOLTAGE_ADC_POWER];
            dac_gain_db <= gain_nxt[`POS_DAC_GAIN_HI:`POS_DAC_GAIN_LO];
            edge_rate_code <=
                gain_nxt[`POS_EDGE_RATE_HI:`POS_EDGE_RATE_LO];
            current_channel_silence <= mute_nxt[`BIT_CURRENT_SILENCE];
            voltage_channel_silence <= mute_nxt[`BIT_VOLTAGE_SILENCE];
            // code 3 is passed through; analog side treats it as undefined
            sense_range_code <= sense_range_e'(
                range_nxt[`POS_SENSE_RANGE_HI:`POS_SENSE_RANGE_LO]);
            boost_level_scheme <= boost_scheme_e'(
                boost_nxt[`BIT_BOOST_LEVEL_SCHEME]);
        end
    end

    property p_power_write;
        @(posedge mclk) disable iff (!rst_n)
        wr_sel[0] |=> speaker_stage_power == $past(reg_wdata[7]) &&
                      boost_power == $past(reg_wdata[5]) &&
                      current_adc_power == $past(reg_wdata[1]) &&
                      voltage_adc_power == $past(reg_wdata[0]);
    endproperty
    a_power_write: assert property (p_power_write)
        else $error("power enables do not follow write");

    property p_gain;
        @(posedge mclk) disable iff (!rst_n)
        wr_sel[1] |=> dac_gain_db == $past(reg_wdata[6:3]);
    endproperty
    a_gain: assert property (p_gain)
        else $error("dac gain does not follow write");

    property p_edge;
        @(posedge mclk) disable iff (!rst_n)
        wr_sel[1] |=> edge_rate_code == $past(reg_wdata[2:0]);
    endproperty
    a_edge: assert property (p_edge)
        else $error("edge rate does not follow write");

    property p_mute;
        @(posedge mclk) disable iff (!rst_n)
        wr_sel[2] |=> current_channel_silence == $past(reg_wdata[1]) &&
                      voltage_channel_silence == $past(reg_wdata[0]);
    endproperty
    a_mute: assert property (p_mute)
        else $error("mute bits do not follow write");

    property p_range;
        @(posedge mclk) disable iff (!rst_n)
        wr_sel[3] |=> sense_range_code == $past(reg_wdata[2:1]);
    endproperty
    a_range: assert property (p_range)
        else $error("sense range does not follow write");

    property p_multi;
        @(posedge mclk) disable iff (!rst_n)
        (wr_sel[4] && !reg_wdata[0]) |=>
            boost_level_scheme == BOOST_MULTI_LEVEL;
    endproperty
    a_multi: assert property (p_multi)
        else $error("boost not multi-level after bit0 low");

    property p_single;
        @(posedge mclk) disable iff (!rst_n)
        (wr_sel[4] && reg_wdata[0]) |=>
            boost_level_scheme == BOOST_SINGLE_LEVEL;
    endproperty
    a_single: assert property (p_single)
        else $error("boost not single-level after bit0 high");

    property p_readback;
        @(posedge mclk) disable iff (!rst_n)
        (reg_wr && addr_ok) ##1 (reg_rd && !reg_wr &&
            reg_addr == $past(reg_addr)) |=> reg_rdata == $past(reg_wdata, 2);
    endproperty
    a_readback: assert property (p_readback)
        else $error("register does not read back written byte");

    property p_hold;
        @(posedge mclk) disable iff (!rst_n)
        !wr_sel[1] |=> $stable(dac_gain_db);
    endproperty
    a_hold: assert property (p_hold)
        else $error("dac gain changed without write");

    property p_unmapped;
        @(posedge mclk) disable iff (!rst_n)
        (reg_rd && !addr_ok) |=> reg_rdata == 8'h00 && !reg_hit;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");

    // no disable here: this one watches the reset itself
    property p_reset_zero;
        @(posedge mclk)
        !rst_n |=> reg_rdata == 8'h00 && !reg_hit && !speaker_stage_power &&
                   !boost_power && !current_adc_power && !voltage_adc_power &&
                   dac_gain_db == 4'h0 && edge_rate_code == 3'h0 &&
                   !current_channel_silence && !voltage_channel_silence &&
                   sense_range_code == RANGE_8_OHM &&
                   boost_level_scheme == BOOST_MULTI_LEVEL;
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("outputs not zero after reset");

    property p_power_hold;
        @(posedge mclk) disable iff (!rst_n)
        !wr_sel[0] |=> $stable({speaker_stage_power, boost_power,
                                current_adc_power, voltage_adc_power});
    endproperty
    a_power_hold: assert property (p_power_hold)
        else $error("power enables changed without write");

    property p_boost_hold;
        @(posedge mclk) disable iff (!rst_n)
        !wr_sel[4] |=> $stable(boost_level_scheme);
    endproperty
    a_boost_hold: assert property (p_boost_hold)
        else $error("boost scheme changed without write");

    c_speaker_on: cover property (@(posedge mclk) disable iff (!rst_n)
        $rose(speaker_stage_power));
    c_max_gain: cover property (@(posedge mclk) disable iff (!rst_n)
        dac_gain_db == 4'hf);
    c_single: cover property (@(posedge mclk) disable iff (!rst_n)
        boost_level_scheme == BOOST_SINGLE_LEVEL);
    c_range4: cover property (@(posedge mclk) disable iff (!rst_n)
        sense_range_code == RANGE_4_OHM);
endmodule

// file: amp_power_gain_config_tb.sv
`timescale 1ns/1ps
`include "amp_power_gain_config_params.svh"
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %0h got %0h", nm, e, g); end end

module amp_power_gain_config_tb
    import amp_cfg_pkg::*;
;
    logic          mclk, rst_n, wr, rd;
    logic [7:0]    addr, wdata, rdata;
    logic          hit, spk, bst, ipw, vpw, isil, vsil;
    logic [3:0]    gain;
    logic [2:0]    erate;
    sense_range_e  rng;
    boost_scheme_e scheme;
    logic [15:0]   fields;
    int            errors, n_checks;
    int            pos [4] = '{7, 5, 1, 0};

    amp_power_gain_config amp_power_gain_config_inst (
        .mclk(mclk), .rst_n(rst_n), .reg_wr(wr), .reg_rd(rd),
        .reg_addr(addr), .reg_wdata(wdata), .reg_rdata(rdata),
        .reg_hit(hit), .speaker_stage_power(spk), .boost_power(bst),
        .current_adc_power(ipw), .voltage_adc_power(vpw),
        .dac_gain_db(gain), .edge_rate_code(erate),
        .current_channel_silence(isil), .voltage_channel_silence(vsil),
        .sense_range_code(rng), .boost_level_scheme(scheme)
    );
    assign fields = {spk, bst, ipw, vpw, gain, erate, isil, vsil, rng, scheme};

    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end

    // strobes are one-cycle pulses; results are sampled 2 ns after the edge
    task automatic wr_reg(input logic [7:0] a, d, input logic h);
        @(posedge mclk);
        #2;
        wr = 1'b1;
        addr = a;
        wdata = d;
        @(posedge mclk);
        #2;
        wr = 1'b0;
        `CHK("write hit", h, hit)
    endtask

    task automatic rd_reg(input logic [7:0] a, e, input logic h);
        @(posedge mclk);
        #2;
        rd = 1'b1;
        addr = a;
        @(posedge mclk);
        #2;
        rd = 1'b0;
        `CHK("read data", e, rdata)
        `CHK("read hit", h, hit)
    endtask

    task automatic done_test(input string nm);
        $display("test %s done, mismatches so far %0d", nm, errors);
    endtask

    task automatic close_out();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    initial begin
        rst_n = 1'b0;
        {wr, rd, addr, wdata, errors, n_checks} = '0;
        repeat (8) @(posedge mclk);
        #2;
        rst_n = 1'b1;
        for (int i = 5; i < 10; i++) rd_reg(8'(i), 8'h00, 1'b1);
        `CHK("fields", 16'h0, fields)
        done_test("reset");
        for (int i = 0; i < 4; i++) begin
            wr_reg(`OFS_BLOCK_POWER_ENABLES, 8'(1 << pos[i]),
                   1'b1);
            `CHK("power", 4'(8 >> i), {spk, bst, ipw, vpw})
        end
        wr_reg(`OFS_BLOCK_POWER_ENABLES, 8'h5c, 1'b1);
        `CHK("power reserved", 4'h0, {spk, bst, ipw, vpw})
        rd_reg(`OFS_BLOCK_POWER_ENABLES, 8'h5c, 1'b1);
        wr_reg(`OFS_BLOCK_POWER_ENABLES, 8'ha3, 1'b1);
        done_test("power");
        for (int i = 0; i < 16; i++) begin
            wr_reg(`OFS_GAIN_AND_EDGE_RATE, {i[0], i[3:0], i[2:0]},
                   1'b1);
            `CHK("gain", i[3:0], gain)
            `CHK("edge", i[2:0], erate)
        end
        rd_reg(`OFS_GAIN_AND_EDGE_RATE, 8'hff, 1'b1);
        done_test("gain");
        for (int i = 0; i < 4; i++) begin
            wr_reg(`OFS_SENSE_MUTE_CONTROL, {6'h15, i[1:0]},
                   1'b1);
            `CHK("mute", i[1:0], {isil, vsil})
        end
        for (int i = 0; i < 4; i++) begin
            wr_reg(`OFS_SENSE_RANGE_CONTROL, {5'h0, i[1:0], i[0]},
                   1'b1);
            `CHK("range", sense_range_e'(i[1:0]), rng)
        end
        rd_reg(`OFS_SENSE_RANGE_CONTROL, 8'h07, 1'b1);
        done_test("mute and range");
        wr_reg(`OFS_BOOST_MODE_CONTROL, 8'h01, 1'b1);
        `CHK("boost single", BOOST_SINGLE_LEVEL, scheme)
        wr_reg(`OFS_BOOST_MODE_CONTROL, 8'hfe, 1'b1);
        `CHK("boost multi", BOOST_MULTI_LEVEL, scheme)
        rd_reg(`OFS_BOOST_MODE_CONTROL, 8'hfe, 1'b1);
        done_test("boost");
        // write then read on the very next edge, as the port allows
        @(posedge mclk);
        #2;
        {wr, addr, wdata} = {1'b1, `OFS_GAIN_AND_EDGE_RATE, 8'h7d};
        @(posedge mclk);
        #2;
        {wr, rd} = 2'b01;
        `CHK("gain b2b", 4'hf, gain)
        `CHK("edge b2b", 3'h5, erate)
        @(posedge mclk);
        #2;
        rd = 1'b0;
        `CHK("read b2b", 8'h7d, rdata)
        `CHK("hit b2b", 1'b1, hit)
        // host fitted with a 4 ohm speaker picks the nearest range code
        wr_reg(`OFS_SENSE_RANGE_CONTROL, 8'h04, 1'b1);
        `CHK("range 4 ohm", RANGE_4_OHM, rng)
        done_test("back to back");
        // unmapped neighbours must neither store nor answer
        wr_reg(8'h04, 8'hff, 1'b0);
        wr_reg(8'h0a, 8'hff, 1'b0);
        rd_reg(8'h04, 8'h00, 1'b0);
        rd_reg(8'h0a, 8'h00, 1'b0);
        rd_reg(`OFS_BLOCK_POWER_ENABLES, 8'ha3, 1'b1);
        `CHK("power kept", 4'hf, {spk, bst, ipw, vpw})
        @(posedge mclk);
        #2;
        {wr, rd, addr, wdata} = {2'b11, `OFS_SENSE_MUTE_CONTROL, 8'h02};
        @(posedge mclk);
        #2;
        {wr, rd} = 2'b00;
        `CHK("old on collide", 8'h57, rdata)
        `CHK("mute new", 2'b10, {isil, vsil})
        done_test("unmapped and collide");
        rst_n = 1'b0;
        repeat (2) @(posedge mclk);
        #2;
        rst_n = 1'b1;
        `CHK("fields again", 16'h0, fields)
        rd_reg(`OFS_GAIN_AND_EDGE_RATE, 8'h00, 1'b1);
        done_test("second reset");
        close_out();
    end
endmodule
